// ---- verilog/mig_pkg.sv ----
// Constants, register map and carrier types of the inter-packet-gap timer
//
// What this block does
// - A 7-bit back-to-back gap field sets the least idle time, in nibble times, between two back-to-back packets.
// - In full duplex the back-to-back gap field holds the wanted gap less 3, with 'h15 the recommended value.
// - In half duplex the back-to-back gap field holds the wanted gap less 6, with 'h12 the recommended value.
// - A non-back-to-back gap first times a 7-bit carrier-sense window, and carrier seen inside it makes the MAC defer.
// - Carrier seen after the window has run out does not defer; the second part is timed and the packet goes anyway.
// - A 7-bit second gap part field sets the whole non-back-to-back gap and starts at 'h12.
// - The duplex select bit picks full duplex when set and half duplex when clear, and so the back-to-back offset.
package mig_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [31:0] ADDR_B2B_GAP   = 32'hff800408;
	localparam logic [31:0] ADDR_NB2B_GAP  = 32'hff80040c;
	localparam logic [31:0] ADDR_MODE_CTRL = 32'hff800420;
	localparam logic [31:0] ADDR_STATUS    = 32'hff800424;

	// ----------------------------------------------------------------
	// Field layout
	// ----------------------------------------------------------------
	localparam int GAP_W        = 7;
	localparam int WIN_LSB      = 8;
	localparam int PART2_LSB    = 0;
	localparam int DUPLEX_BIT   = 0;
	localparam int SPEED10_BIT  = 1;
	localparam int CNT_W        = 8;
	localparam int STATE_LSB    = 8;

	// ----------------------------------------------------------------
	// Reset values and offsets
	// ----------------------------------------------------------------
	localparam logic [GAP_W-1:0] RST_B2B_GAP = 7'h12;
	localparam logic [GAP_W-1:0] RST_WINDOW  = 7'h0c;
	localparam logic [GAP_W-1:0] RST_PART2   = 7'h12;
	localparam logic [CNT_W-1:0] OFS_FULL    = 8'h03;
	localparam logic [CNT_W-1:0] OFS_HALF    = 8'h06;
	localparam logic [1:0]       RESP_OKAY   = 2'h0;
	localparam logic [1:0]       RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Timing: nibble times derived from the 100 MHz clock
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int NIB_NS_100M   = 40;
	localparam int NIB_NS_10M    = 400;
	localparam int NIB_CYC_100M  = NIB_NS_100M / CLK_PERIOD_NS;
	localparam int NIB_CYC_10M   = NIB_NS_10M / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_CS_WIN = 6'h01,
		ST_PART2  = 6'h02,
		ST_DEFER  = 6'h04,
		ST_B2B    = 6'h08,
		ST_READY  = 6'h10,
		ST_TX     = 6'h20
	} mig_state_t;

	typedef struct packed {
		logic [GAP_W-1:0] carrier_sense_window;
		logic [GAP_W-1:0] second_gap_part;
	} mig_nb2b_cfg_t;

	typedef struct packed {
		logic duplex_select;
		logic speed_10;
	} mig_mode_t;

endpackage

// ---- verilog/mig_nibble_div.sv ----
// Divider that turns the system clock into one-cycle nibble-time pulses
`timescale 1ns/1ps
module mig_nibble_div #(
	parameter int DIV_FAST = mig_pkg::NIB_CYC_100M,
	parameter int DIV_SLOW = mig_pkg::NIB_CYC_10M
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic speed_10,
	output logic      nibble_tick
);

	logic [5:0] div_q;

	// Reload picks the nibble length of the selected line rate
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			div_q       <= 6'h00;
			nibble_tick <= 1'b0;
		end
		else if (div_q == 6'h00)
		begin
			div_q       <= speed_10 ? 6'(DIV_SLOW - 1) : 6'(DIV_FAST - 1);
			nibble_tick <= 1'b1;
		end
		else
		begin
			div_q       <= div_q - 6'h01;
			nibble_tick <= 1'b0;
		end
	end

endmodule

// ---- verilog/mig_gap_cnt.sv ----
// Saturating nibble counter used to time the gap phases
`timescale 1ns/1ps
module mig_gap_cnt #(
	parameter int W = mig_pkg::CNT_W
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         clr,
	input  wire logic         step,
	output logic [W-1:0]      count
);

	// Clear wins over a step; the count holds at its top value
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			count <= '0;
		else if (clr)
			count <= '0;
		else if (step && (count != {W{1'b1}}))
			count <= count + 1'b1;
	end

endmodule

// ---- verilog/mig_gap_timer.sv ----
// Inter-packet-gap and carrier-deference timer with its AXI4-Lite register slave
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
module mig_gap_timer (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// AXI4-Lite slave
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Transmit path and PHY
	input  wire logic        carrier_sense,
	input  wire logic        tx_start,
	input  wire logic        tx_end,
	input  wire logic        tx_b2b,
	output logic             tx_grant_q,
	output logic             defer_q
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [mig_pkg::GAP_W-1:0] back_to_back_gap_q;
	mig_pkg::mig_nb2b_cfg_t    nb2b_cfg_q;
	mig_pkg::mig_mode_t        mode_q;
	mig_pkg::mig_state_t       state_q;
	mig_pkg::mig_state_t       state_d;
	logic [mig_pkg::CNT_W-1:0] gap_count;
	logic [mig_pkg::CNT_W-1:0] b2b_target;
	logic [mig_pkg::CNT_W-1:0] win_target;
	logic [mig_pkg::CNT_W-1:0] part2_target;
	logic                      nibble_tick;
	logic                      cnt_clr;
	logic                      wr_fire;
	logic                      rd_fire;
	logic                      wr_hit;
	logic                      rd_hit;
	logic [31:0]               rd_word;
	logic                      wr_offer;
	logic                      wr_b2b;
	logic                      wr_nb2b;
	logic                      wr_mode;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------

	// True when the address names one of the block's registers
	function automatic logic reg_mapped(input logic [31:0] addr);
		reg_mapped = (addr == mig_pkg::ADDR_B2B_GAP) || (addr == mig_pkg::ADDR_NB2B_GAP)
			|| (addr == mig_pkg::ADDR_MODE_CTRL) || (addr == mig_pkg::ADDR_STATUS);
	endfunction

	assign wr_hit = reg_mapped(s_axi_awaddr);
	assign rd_hit = reg_mapped(s_axi_araddr);

	// Register selected by the write address
	assign wr_b2b  = (s_axi_awaddr == mig_pkg::ADDR_B2B_GAP);
	assign wr_nb2b = (s_axi_awaddr == mig_pkg::ADDR_NB2B_GAP);
	assign wr_mode = (s_axi_awaddr == mig_pkg::ADDR_MODE_CTRL);

	// ----------------------------------------------------------------
	// Write channel: address and data taken in the same cycle
	// ----------------------------------------------------------------
	assign wr_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

	// Both halves offered, no take in flight and no answer pending
	assign wr_offer = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;

	// Ready pulses once both halves of a write are offered and no answer is pending
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end
		else
		begin
			s_axi_awready <= wr_offer;
			s_axi_wready  <= wr_offer;
		end
	end

	// Write response stands until the master takes it
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= mig_pkg::RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? mig_pkg::RESP_OKAY : mig_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------

	// Gap fields sit in byte lanes 0 and 1; reserved bits are not stored
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			back_to_back_gap_q              <= mig_pkg::RST_B2B_GAP;
			nb2b_cfg_q.carrier_sense_window <= mig_pkg::RST_WINDOW;
			nb2b_cfg_q.second_gap_part      <= mig_pkg::RST_PART2;
			mode_q.duplex_select            <= 1'b0;
			mode_q.speed_10                 <= 1'b0;
		end
		else if (wr_fire)
		begin
			if (wr_b2b && s_axi_wstrb[0])
				back_to_back_gap_q <= s_axi_wdata[mig_pkg::PART2_LSB +: mig_pkg::GAP_W];
			if (wr_nb2b)
			begin
				if (s_axi_wstrb[1])
					nb2b_cfg_q.carrier_sense_window <= s_axi_wdata[mig_pkg::WIN_LSB +: mig_pkg::GAP_W];
				if (s_axi_wstrb[0])
					nb2b_cfg_q.second_gap_part <= s_axi_wdata[mig_pkg::PART2_LSB +: mig_pkg::GAP_W];
			end
			if (wr_mode && s_axi_wstrb[0])
			begin
				mode_q.duplex_select <= s_axi_wdata[mig_pkg::DUPLEX_BIT];
				mode_q.speed_10      <= s_axi_wdata[mig_pkg::SPEED10_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	// Read word assembled from the register file and live timer state
	always_comb
	begin
		rd_word = 32'h00000000;
		unique case (s_axi_araddr)
			mig_pkg::ADDR_B2B_GAP:
				rd_word[mig_pkg::PART2_LSB +: mig_pkg::GAP_W] = back_to_back_gap_q;
			mig_pkg::ADDR_NB2B_GAP:
			begin
				rd_word[mig_pkg::WIN_LSB +: mig_pkg::GAP_W]   = nb2b_cfg_q.carrier_sense_window;
				rd_word[mig_pkg::PART2_LSB +: mig_pkg::GAP_W] = nb2b_cfg_q.second_gap_part;
			end
			mig_pkg::ADDR_MODE_CTRL:
			begin
				rd_word[mig_pkg::DUPLEX_BIT]  = mode_q.duplex_select;
				rd_word[mig_pkg::SPEED10_BIT] = mode_q.speed_10;
			end
			mig_pkg::ADDR_STATUS:
			begin
				rd_word[0 +: mig_pkg::CNT_W]          = gap_count;
				rd_word[mig_pkg::STATE_LSB +: $bits(mig_pkg::mig_state_t)] = state_q;
			end
			default:
				rd_word = 32'h00000000;
		endcase
	end

	// Address ready pulses while no read answer is pending
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			s_axi_arready <= 1'b0;
		else
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
	end

	// Read data stands until the master takes it
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= mig_pkg::RESP_OKAY;
		end
		else if (rd_fire)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_hit ? mig_pkg::RESP_OKAY : mig_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Nibble timebase and gap counter
	// ----------------------------------------------------------------
	// A new line rate takes hold at the next reload, so one nibble may still run at the old length
	mig_nibble_div u_div (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.speed_10    (mode_q.speed_10),
		.nibble_tick (nibble_tick)
	);

	mig_gap_cnt #(
		.W (mig_pkg::CNT_W)
	) u_cnt (
		.clk     (clk),
		.sys_rst (sys_rst),
		.clr     (cnt_clr),
		.step    (nibble_tick),
		.count   (gap_count)
	);

	// ----------------------------------------------------------------
	// Gap targets in nibble times
	// ----------------------------------------------------------------

	// Back-to-back field stores the gap less the duplex offset
	assign b2b_target = {1'b0, back_to_back_gap_q}
		+ (mode_q.duplex_select ? mig_pkg::OFS_FULL : mig_pkg::OFS_HALF);
	assign win_target   = {1'b0, nb2b_cfg_q.carrier_sense_window};
	assign part2_target = {1'b0, nb2b_cfg_q.second_gap_part};

	// ----------------------------------------------------------------
	// Gap state machine
	// ----------------------------------------------------------------

	// Next state of the deference and gap sequence
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			mig_pkg::ST_CS_WIN:
				if (carrier_sense)
					state_d = mig_pkg::ST_DEFER;
				else if (gap_count >= win_target)
					state_d = mig_pkg::ST_PART2;
			mig_pkg::ST_PART2:
				if (gap_count >= part2_target)
					state_d = mig_pkg::ST_READY;
			mig_pkg::ST_DEFER:
				if (!carrier_sense)
					state_d = mig_pkg::ST_CS_WIN;
			mig_pkg::ST_B2B:
				if (gap_count >= b2b_target)
					state_d = mig_pkg::ST_READY;
			mig_pkg::ST_READY:
				if (tx_start)
					state_d = mig_pkg::ST_TX;
			mig_pkg::ST_TX:
				if (tx_end)
					state_d = tx_b2b ? mig_pkg::ST_B2B : mig_pkg::ST_CS_WIN;
			default:
				state_d = mig_pkg::ST_CS_WIN;
		endcase
	end

	// Counter restarts on entry to a timed phase; the second part keeps counting on
	assign cnt_clr = (state_d != state_q)
		&& ((state_d == mig_pkg::ST_CS_WIN) || (state_d == mig_pkg::ST_B2B));

	// State register
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			state_q <= mig_pkg::ST_CS_WIN;
		else
			state_q <= state_d;
	end

	// Grant follows the next state, so it rises one cycle after the gap is met
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			tx_grant_q <= 1'b0;
		else
			tx_grant_q <= (state_d == mig_pkg::ST_READY);
	end

	// Deference follows the next state and stands while carrier holds
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			defer_q <= 1'b0;
		else
			defer_q <= (state_d == mig_pkg::ST_DEFER);
	end

endmodule

// ---- verification/mig_gap_timer_monitor.sv ----
// Checker of gap timing, deferral and write handshake at the timer's ports
`timescale 1ns/1ps
module mig_gap_timer_monitor (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        carrier_sense,
	input wire logic        tx_start,
	input wire logic        tx_end,
	input wire logic        tx_b2b,
	input wire logic        tx_grant_q,
	input wire logic        defer_q
);
	// ------------------------------------------------
	// Shadow settings and gap tracking
	// ------------------------------------------------
	logic [6:0]  b2b_q, win_q, p2_q;
	logic [1:0]  mode_q;
	logic [11:0] cnt_q;
	logic        tx_q, gap_q, bb_q, sd_q;
	int          nib, lo, pmin, wend;

	// Copies of the settings, taken as each write is accepted
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
		begin
			b2b_q <= mig_pkg::RST_B2B_GAP;
			{win_q, p2_q} <= {mig_pkg::RST_WINDOW, mig_pkg::RST_PART2};
			mode_q <= 2'h0;
		end
		else if (s_axi_awvalid && s_axi_awready)
			case (s_axi_awaddr)
				mig_pkg::ADDR_B2B_GAP:   b2b_q <= s_axi_wdata[6:0];
				mig_pkg::ADDR_NB2B_GAP:  {win_q, p2_q} <= {s_axi_wdata[14:8], s_axi_wdata[6:0]};
				mig_pkg::ADDR_MODE_CTRL: mode_q <= s_axi_wdata[1:0];
				default:                 mode_q <= mode_q;
			endcase

	// Cycles since the accepted end of packet, until the grant returns
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
		begin
			{tx_q, gap_q, bb_q, sd_q} <= 4'h0;
			cnt_q <= 12'h000;
		end
		else if (tx_q && tx_end)
		begin
			{tx_q, gap_q, bb_q, sd_q} <= {2'h1, tx_b2b, 1'h0};
			cnt_q <= 12'h001;
		end
		else
		begin
			tx_q <= tx_q | (tx_start & tx_grant_q);
			gap_q <= gap_q & ~tx_grant_q;
			sd_q <= sd_q | defer_q;
			cnt_q <= cnt_q + {11'h000, cnt_q != 12'hfff};
		end

	// Bounds for the current settings, with one nibble of phase slack
	always_comb
	begin
		nib = mode_q[1] ? mig_pkg::NIB_CYC_10M : mig_pkg::NIB_CYC_100M;
		lo = (int'(b2b_q) + (mode_q[0] ? 3 : 6) - 1) * nib;
		pmin = (int'(p2_q) - 1) * nib;
		wend = (int'(win_q) + 1) * nib + 4;
	end

	// ------------------------------------------------
	// Assertions
	// ------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_defer_soon; ##[1:2] defer_q; endsequence
	sequence s_write_done; s_axi_awready && s_axi_wready ##1 s_axi_bvalid; endsequence

	property p_b2b_early; $rose(tx_grant_q) && gap_q && bb_q |-> int'(cnt_q) >= lo; endproperty
	a_b2b_early: assert property (p_b2b_early) else $error("back-to-back grant too early");
	property p_b2b_late; gap_q && bb_q && int'(cnt_q) == lo + 2 * nib + 3 |-> tx_grant_q; endproperty
	a_b2b_late: assert property (p_b2b_late) else $error("back-to-back grant too late");
	property p_nb_early; $rose(tx_grant_q) && gap_q && !bb_q |-> int'(cnt_q) >= pmin; endproperty
	a_nb_early: assert property (p_nb_early) else $error("second gap part cut short");
	property p_defer_win;
		gap_q && !bb_q && !sd_q && carrier_sense && cnt_q > 12'h004 && int'(cnt_q) + nib < int'(win_q) * nib
		|-> s_defer_soon;
	endproperty
	a_defer_win: assert property (p_defer_win) else $error("no deferral to carrier in window");
	property p_late; gap_q && !bb_q && !sd_q && int'(cnt_q) > wend |-> !defer_q; endproperty
	a_late: assert property (p_late) else $error("deferral after window expired");
	property p_defer_cause; $rose(defer_q) |-> $past(carrier_sense) || $past(carrier_sense, 2); endproperty
	a_defer_cause: assert property (p_defer_cause) else $error("deferral without carrier");
	property p_defer_grant; defer_q |-> !tx_grant_q; endproperty
	a_defer_grant: assert property (p_defer_grant) else $error("grant while deferring");
	property p_grant_drop; tx_start && tx_grant_q |-> ##[1:2] !tx_grant_q; endproperty
	a_grant_drop: assert property (p_grant_drop) else $error("grant kept after start");
	property p_write; s_axi_awready |-> s_write_done; endproperty
	a_write: assert property (p_write) else $error("write accept without response");
endmodule

// ---- verification/mig_phy_model.sv ----
// Carrier side of the PHY: raises carrier for a commanded number of cycles
`timescale 1ns/1ps
module mig_phy_model (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [15:0] burst_len,
	input  wire logic        burst_go,
	output logic             carrier_sense
);
	logic [15:0] left_q;

	// Carrier may come at any point of the gap, window or not
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
			left_q <= 16'h0000;
		else if (burst_go)
			left_q <= burst_len;
		else if (left_q != 16'h0000)
			left_q <= left_q - 16'h0001;

	assign carrier_sense = (left_q != 16'h0000);
endmodule

// ---- verification/mig_gap_timer_test.sv ----
// Self-checking bench of the inter-packet-gap timer
`timescale 1ns/1ps
module mig_gap_timer_test;
	// ------------------------------------------------
	// Signals, design and carrier model
	// ------------------------------------------------
	logic        clk = 1'h0, sys_rst = 1'h1, tx_start = 1'h0, tx_end = 1'h0, tx_b2b = 1'h0, burst_go = 1'h0;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [15:0] burst_len = 16'h0;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        carrier_sense, tx_grant_q, defer_q;
	int          n_fail = 0, n_compared = 0, cyc = 0;

	mig_gap_timer dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .carrier_sense, .tx_start,
		.tx_end, .tx_b2b, .tx_grant_q, .defer_q);
	mig_phy_model phy (.clk, .sys_rst, .burst_len, .burst_go, .carrier_sense);

	// Clock and hang limit
	initial
	begin
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_fail++;
			report_and_stop();
		end
	end

	// ------------------------------------------------
	// Compares, bus cycles and packets
	// ------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_rng(input string what, input int lo, input int hi, input int got);
		n_compared++;
		if (got < lo || got > hi)
		begin
			n_fail++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask

	task automatic report_and_stop();
		$display("Compared %0d, mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Write one word and judge its response code
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do @(posedge clk); while (s_axi_awready !== 1'h1);
		s_axi_awvalid <= 1'h0;
		s_axi_wvalid <= 1'h0;
		do @(posedge clk); while (s_axi_bvalid !== 1'h1);
		chk("bresp", er, s_axi_bresp);
		s_axi_bready <= 1'h0;
	endtask

	// Read one word and judge data and response code
	task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do @(posedge clk); while (s_axi_rvalid !== 1'h1);
		chk("rdata", ed, s_axi_rdata);
		chk("rresp", er, s_axi_rresp);
		s_axi_rready <= 1'h0;
	endtask

	// One packet, then count edges until the grant returns; carrier burst at edge c_at
	task automatic pkt(input logic b2b, input int c_at, input int c_len, output int n, output logic sd);
		sd = 1'h0;
		do @(posedge clk); while (tx_grant_q !== 1'h1);
		tx_start <= 1'h1;
		@(posedge clk);
		tx_start <= 1'h0;
		repeat (3) @(posedge clk);
		tx_end <= 1'h1;
		tx_b2b <= b2b;
		@(posedge clk);
		tx_end <= 1'h0;
		n = 0;
		while (tx_grant_q !== 1'h1)
		begin
			burst_go <= (n == c_at);
			burst_len <= 16'(c_len);
			@(posedge clk);
			n++;
			sd = sd | (defer_q === 1'h1);
		end
		burst_go <= 1'h0;
	endtask

	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	task automatic t_regs();
		axi_rd(mig_pkg::ADDR_B2B_GAP, 32'h12, mig_pkg::RESP_OKAY);
		axi_rd(mig_pkg::ADDR_NB2B_GAP, 32'h0c12, mig_pkg::RESP_OKAY);
		axi_rd(mig_pkg::ADDR_MODE_CTRL, 32'h0, mig_pkg::RESP_OKAY);
		axi_wr(mig_pkg::ADDR_B2B_GAP, 32'hffffffff, mig_pkg::RESP_OKAY);
		axi_rd(mig_pkg::ADDR_B2B_GAP, 32'h7f, mig_pkg::RESP_OKAY);
		axi_wr(mig_pkg::ADDR_NB2B_GAP, 32'hffffffff, mig_pkg::RESP_OKAY);
		axi_rd(mig_pkg::ADDR_NB2B_GAP, 32'h7f7f, mig_pkg::RESP_OKAY);
		s_axi_wstrb <= 4'h2;
		axi_wr(mig_pkg::ADDR_NB2B_GAP, 32'h00000c00, mig_pkg::RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		axi_rd(mig_pkg::ADDR_NB2B_GAP, 32'h0c7f, mig_pkg::RESP_OKAY);
		axi_wr(32'hff800500, 32'h1, mig_pkg::RESP_SLVERR);
		axi_rd(32'hff800500, 32'h0, mig_pkg::RESP_SLVERR);
		axi_wr(mig_pkg::ADDR_NB2B_GAP, 32'h0c12, mig_pkg::RESP_OKAY);
		$display("t_regs done");
	endtask

	// Both duplex offsets, boundary gaps and the slow nibble rate
	task automatic t_b2b();
		logic [1:0] md [5] = '{2'h0, 2'h1, 2'h1, 2'h0, 2'h2};
		logic [6:0] gp [5] = '{7'h12, 7'h15, 7'h01, 7'h00, 7'h02};
		int         nib, ofs, n;
		logic       sd;
		for (int i = 0; i < 5; i++)
		begin
			axi_wr(mig_pkg::ADDR_MODE_CTRL, {30'h0, md[i]}, mig_pkg::RESP_OKAY);
			axi_wr(mig_pkg::ADDR_B2B_GAP, {25'h0, gp[i]}, mig_pkg::RESP_OKAY);
			nib = md[i][1] ? mig_pkg::NIB_CYC_10M : mig_pkg::NIB_CYC_100M;
			ofs = md[i][0] ? 3 : 6;
			pkt(1'h1, -1, 0, n, sd);
			chk_rng("b2b gap", (int'(gp[i]) + ofs - 1) * nib, (int'(gp[i]) + ofs + 1) * nib + 3, n);
		end
		$display("t_b2b done");
	endtask

	// Window of 4 nibbles, second part 'h12: quiet, carrier inside, carrier after
	task automatic t_nb();
		int   n;
		logic sd;
		axi_wr(mig_pkg::ADDR_MODE_CTRL, 32'h0, mig_pkg::RESP_OKAY);
		// Let the last slow nibble run out before timing fast gaps
		repeat (mig_pkg::NIB_CYC_10M) @(posedge clk);
		axi_wr(mig_pkg::ADDR_NB2B_GAP, 32'h0412, mig_pkg::RESP_OKAY);
		pkt(1'h0, -1, 0, n, sd);
		chk_rng("quiet gap", 68, 79, n);
		chk("quiet defer", 1'h0, sd);
		pkt(1'h0, 2, 20, n, sd);
		chk("window defer", 1'h1, sd);
		chk_rng("deferred gap", 22, 110, n);
		pkt(1'h0, 40, 10, n, sd);
		chk("late carrier defer", 1'h0, sd);
		chk_rng("late carrier gap", 68, 79, n);
		// Status ignores writes; idle in ready state, the count saturates
		axi_wr(mig_pkg::ADDR_STATUS, 32'h0, mig_pkg::RESP_OKAY);
		repeat (1100) @(posedge clk);
		axi_rd(mig_pkg::ADDR_STATUS, 32'h000010ff, mig_pkg::RESP_OKAY);
		$display("t_nb done");
	endtask

	initial
	begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'h0;
		t_regs();
		t_b2b();
		t_nb();
		report_and_stop();
	end
endmodule

bind mig_gap_timer mig_gap_timer_monitor mon (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wready, .s_axi_bvalid, .carrier_sense, .tx_start, .tx_end, .tx_b2b, .tx_grant_q, .defer_q);
